/* File: hdl/oled_host_bus_consts.svh */
`ifndef OLED_HOST_BUS_CONSTS_SVH
`define OLED_HOST_BUS_CONSTS_SVH

// Protocol select codes, written as {protocol_select_1, protocol_select_0}
`define SEL_SPI3       2'h1
`define SEL_SPI4       2'h0
`define SEL_M68        2'h3
`define SEL_I80        2'h2

// Bit positions in the display end's sampled pin vector
`define PIN_W          15
`define PIN_CS         8
`define PIN_E_RD       9
`define PIN_RW_WR      10
`define PIN_DC         11
`define PIN_SEL0       12
`define PIN_SEL1       13
`define PIN_HRST       14
// Idle pin levels: reset released, chip select high, all else low
`define PIN_IDLE       15'h4100

// Serial bit positions on the data bus
`define SER_CLK_BIT    0
`define SER_DATA_BIT   1
`define SER_LAST_BIT   3'h7

// Host timing, in ns, and in cycles of clk_i (least times round up)
`define CLK_PERIOD_NS  50
`define SETUP_NS       50
`define WR_LOW_NS      150
`define RD_LOW_NS      450
`define HOLD_NS        100
`define GAP_NS         150
`define SCK_HALF_NS    100
`define SETUP_CYC      ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_LOW_CYC     ((`WR_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_LOW_CYC     ((`RD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC       ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC        ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCK_HALF_CYC   ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hdl/oled_host_bus_pkg.sv */
package oled_host_bus_pkg;

  typedef enum logic [1:0] {
    MODE_SPI4,
    MODE_SPI3,
    MODE_I80,
    MODE_M68
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_SCK_LO,
    ST_SCK_HI,
    ST_GAP
  } host_state_t;

endpackage : oled_host_bus_pkg

/* File: hdl/oled_host_bus_if.sv */
`timescale 1ns/100ps
interface oled_host_bus_if;
  logic       cs_n;
  logic       dc;
  logic       e_rd;
  logic       rw_wr;
  logic       protocol_select_0;
  logic       protocol_select_1;
  logic       hard_reset_n;
  logic [7:0] mcu_bus;
  logic [7:0] mcu_bus_oe;
  logic [7:0] disp_bus;
  logic [7:0] disp_bus_oe;
  logic [7:0] host_data_bus;

  // Wire level per bit: display drives, else host drives, else pulled low
  assign host_data_bus = (disp_bus_oe & disp_bus) | (~disp_bus_oe & mcu_bus_oe & mcu_bus);

  modport display (
    input  cs_n, dc, e_rd, rw_wr, protocol_select_0, protocol_select_1,
    input  hard_reset_n, host_data_bus,
    output disp_bus, disp_bus_oe
  );

  modport mcu (
    output cs_n, dc, e_rd, rw_wr, protocol_select_0, protocol_select_1,
    output hard_reset_n, mcu_bus, mcu_bus_oe,
    input  host_data_bus
  );
endinterface : oled_host_bus_if

/* File: hdl/oled_display_end.sv */
`timescale 1ns/100ps
`include "oled_host_bus_consts.svh"
module oled_display_end
  import oled_host_bus_pkg::*;
(
  input  wire logic        link_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  oled_host_bus_if.display bus,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output logic [7:0]       rx_data_o,
  output logic             rx_is_data_o,
  output logic             rx_room_o,
  output logic             overrun_o,
  input  wire logic [7:0]  rd_data_i,
  output logic             rd_done_o,
  output mode_t            mode_o
);

  logic [`PIN_W-1:0] pin_raw;
  logic [`PIN_W-1:0] pin_meta;
  logic [`PIN_W-1:0] pin_s;
  logic [`PIN_W-1:0] pin_p;
  logic [7:0]        s_bus;
  logic [7:0]        p_bus;
  logic              s_cs_n;
  logic              p_cs_n;
  logic              s_e_rd;
  logic              p_e_rd;
  logic              s_rw_wr;
  logic              p_rw_wr;
  logic              s_dc;
  logic              p_dc;
  logic              s_hrst_n;
  logic [1:0]        s_sel;
  mode_t             next_mode;
  logic              serial;
  logic              wr_m68;
  logic              wr_i80;
  logic              sck_rise;
  logic              byte_done;
  logic              push;
  logic              pop;
  logic [7:0]        push_data;
  logic              push_dc;
  logic              rd_act;
  logic              rd_q;
  logic [6:0]        shift;
  logic [2:0]        bit_cnt;
  logic [8:0]        head;
  logic [8:0]        tail;
  logic [1:0]        count;

  assign pin_raw = {bus.hard_reset_n, bus.protocol_select_1, bus.protocol_select_0, bus.dc,
                    bus.rw_wr, bus.e_rd, bus.cs_n, bus.host_data_bus};

  // Every pin crosses from the host's timing through two flops
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta <= `PIN_IDLE;
      pin_s    <= `PIN_IDLE;
      pin_p    <= `PIN_IDLE;
    end else if (ce_i) begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
      pin_p    <= pin_s;
    end
  end

  assign s_bus    = pin_s[7:0];
  assign p_bus    = pin_p[7:0];
  assign s_cs_n   = pin_s[`PIN_CS];
  assign p_cs_n   = pin_p[`PIN_CS];
  assign s_e_rd   = pin_s[`PIN_E_RD];
  assign p_e_rd   = pin_p[`PIN_E_RD];
  assign s_rw_wr  = pin_s[`PIN_RW_WR];
  assign p_rw_wr  = pin_p[`PIN_RW_WR];
  assign s_dc     = pin_s[`PIN_DC];
  assign p_dc     = pin_p[`PIN_DC];
  assign s_hrst_n = pin_s[`PIN_HRST];
  assign s_sel    = {pin_s[`PIN_SEL1], pin_s[`PIN_SEL0]};

  always_comb begin
    case (s_sel)
      `SEL_SPI3: next_mode = MODE_SPI3;
      `SEL_SPI4: next_mode = MODE_SPI4;
      `SEL_M68:  next_mode = MODE_M68;
      default:   next_mode = MODE_I80;
    endcase
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_o <= MODE_SPI4;
    end else if (ce_i) begin
      mode_o <= next_mode;
    end
  end

  assign serial = (mode_o == MODE_SPI3) || (mode_o == MODE_SPI4);

  // Writes are taken when the strobe closes, with values seen while it was open
  assign wr_m68 = (mode_o == MODE_M68) && p_e_rd && !s_e_rd && !p_cs_n && !p_rw_wr;
  assign wr_i80 = (mode_o == MODE_I80) && !p_rw_wr && s_rw_wr && !p_cs_n;

  // The host grounds both strobe pins in serial mode, so they are not looked at
  assign sck_rise  = serial && !s_cs_n && !p_bus[`SER_CLK_BIT] && s_bus[`SER_CLK_BIT];
  assign byte_done = sck_rise && (bit_cnt == `SER_LAST_BIT);

  always_comb begin
    push      = 1'b0;
    push_data = p_bus;
    push_dc   = p_dc;
    if (s_hrst_n) begin
      if (byte_done) begin
        push      = 1'b1;
        push_data = {shift, s_bus[`SER_DATA_BIT]};
        push_dc   = s_dc;
      end else if (wr_m68 || wr_i80) begin
        push      = 1'b1;
      end
    end
  end

  // Serial shifter: MSB first, count restarts whenever select goes high
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift   <= 7'h00;
      bit_cnt <= 3'h0;
    end else if (ce_i) begin
      if (!s_hrst_n || s_cs_n || !serial) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        shift   <= {shift[5:0], s_bus[`SER_DATA_BIT]};
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // Two-entry buffer; head always sits in its own flop so data leaves from a register
  assign pop        = rx_valid_o && rx_ready_i;
  assign rx_valid_o = (count != 2'h0);
  assign rx_room_o  = (count != 2'h2);
  assign rx_data_o  = head[7:0];
  assign rx_is_data_o = head[8];

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      head      <= 9'h000;
      tail      <= 9'h000;
      count     <= 2'h0;
      overrun_o <= 1'b0;
    end else if (ce_i) begin
      overrun_o <= push && !rx_room_o;
      if (!s_hrst_n) begin
        count <= 2'h0;
      end else begin
        case ({push && rx_room_o, pop})
          2'b10: begin
            if (count == 2'h0) begin
              head <= {push_dc, push_data};
            end else begin
              tail <= {push_dc, push_data};
            end
            count <= count + 2'h1;
          end
          2'b01: begin
            head  <= tail;
            count <= count - 2'h1;
          end
          2'b11: begin
            if (count == 2'h1) begin
              head <= {push_dc, push_data};
            end else begin
              head <= tail;
              tail <= {push_dc, push_data};
            end
          end
          default: begin
            count <= count;
          end
        endcase
      end
    end
  end

  // Read window: the display drives the bus only while the host asks to read
  always_comb begin
    case (mode_o)
      MODE_M68: rd_act = s_e_rd && s_rw_wr;
      MODE_I80: rd_act = !s_e_rd;
      default:  rd_act = 1'b0;
    endcase
    rd_act = rd_act && !s_cs_n && s_hrst_n;
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q            <= 1'b0;
      bus.disp_bus    <= 8'h00;
      bus.disp_bus_oe <= 8'h00;
      rd_done_o       <= 1'b0;
    end else if (ce_i) begin
      rd_q      <= rd_act;
      rd_done_o <= rd_q && !rd_act;
      if (rd_act && !rd_q) begin
        bus.disp_bus    <= rd_data_i;
        bus.disp_bus_oe <= 8'hFF;
      end else if (!rd_act) begin
        bus.disp_bus_oe <= 8'h00;
      end
    end
  end

endmodule : oled_display_end

/* File: hdl/oled_mcu_end.sv */
`timescale 1ns/100ps
`include "oled_host_bus_consts.svh"
module oled_mcu_end
  import oled_host_bus_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  oled_host_bus_if.mcu    bus,
  input  mode_t           mode_i,
  input  wire logic       hw_reset_req_i,
  input  wire logic       req_valid_i,
  output logic            req_ready_o,
  input  wire logic       req_read_i,
  input  wire logic       req_dc_i,
  input  wire logic [7:0] req_data_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o
);

  host_state_t state;
  mode_t       mode;
  logic [7:0]  bus_meta;
  logic [7:0]  bus_s;
  logic [7:0]  tmr;
  logic [7:0]  sdata;
  logic [2:0]  bit_idx;
  logic        rd;
  logic        serial;

  assign serial      = (mode == MODE_SPI3) || (mode == MODE_SPI4);
  assign req_ready_o = (state == ST_IDLE);

  // Read data from the display crosses into this clock through two flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_meta <= 8'h00;
      bus_s    <= 8'h00;
    end else if (ce_i) begin
      bus_meta <= bus.host_data_bus;
      bus_s    <= bus_meta;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus.hard_reset_n      <= 1'b0;
      bus.protocol_select_0 <= 1'b0;
      bus.protocol_select_1 <= 1'b0;
    end else if (ce_i) begin
      bus.hard_reset_n <= !hw_reset_req_i;
      case (mode)
        MODE_SPI3: {bus.protocol_select_1, bus.protocol_select_0} <= `SEL_SPI3;
        MODE_M68:  {bus.protocol_select_1, bus.protocol_select_0} <= `SEL_M68;
        MODE_I80:  {bus.protocol_select_1, bus.protocol_select_0} <= `SEL_I80;
        default:   {bus.protocol_select_1, bus.protocol_select_0} <= `SEL_SPI4;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state          <= ST_IDLE;
      mode           <= MODE_SPI4;
      tmr            <= 8'h00;
      sdata          <= 8'h00;
      bit_idx        <= 3'h0;
      rd             <= 1'b0;
      rsp_valid_o    <= 1'b0;
      rsp_data_o     <= 8'h00;
      bus.cs_n       <= 1'b1;
      bus.dc         <= 1'b0;
      bus.e_rd       <= 1'b0;
      bus.rw_wr      <= 1'b0;
      bus.mcu_bus    <= 8'h00;
      bus.mcu_bus_oe <= 8'hFF;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      if (tmr != 8'h00) begin
        tmr <= tmr - 8'h01;
      end
      case (state)
        ST_IDLE: begin
          mode      <= mode_i;
          bus.e_rd  <= (mode == MODE_I80);
          bus.rw_wr <= !serial;
          if (req_valid_i) begin
            rd    <= req_read_i;
            sdata <= req_data_i;
            if (serial && req_read_i) begin
              rsp_data_o  <= 8'h00;
              rsp_valid_o <= 1'b1;
            end else if (serial) begin
              bus.cs_n    <= 1'b0;
              bus.dc      <= (mode == MODE_SPI4) && req_dc_i;
              bus.mcu_bus <= 8'h00;
              bit_idx     <= 3'h7;
              tmr         <= 8'(`SCK_HALF_CYC - 1);
              state       <= ST_SCK_LO;
            end else begin
              bus.cs_n       <= 1'b0;
              bus.dc         <= req_dc_i;
              bus.rw_wr      <= (mode == MODE_M68) ? req_read_i : 1'b1;
              bus.mcu_bus    <= req_data_i;
              bus.mcu_bus_oe <= req_read_i ? 8'h00 : 8'hFF;
              tmr            <= 8'(`SETUP_CYC - 1);
              state          <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          if (tmr == 8'h00) begin
            if (mode == MODE_M68) begin
              bus.e_rd <= 1'b1;
            end else if (rd) begin
              bus.e_rd <= 1'b0;
            end else begin
              bus.rw_wr <= 1'b0;
            end
            tmr   <= rd ? 8'(`RD_LOW_CYC - 1) : 8'(`WR_LOW_CYC - 1);
            state <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (tmr == 8'h00) begin
            if (rd) begin
              rsp_data_o <= bus_s;
            end
            bus.e_rd  <= (mode == MODE_I80);
            bus.rw_wr <= (mode == MODE_M68) ? rd : 1'b1;
            tmr       <= 8'(`HOLD_CYC - 1);
            state     <= ST_HOLD;
          end
        end
        ST_SCK_LO: begin
          bus.mcu_bus[`SER_CLK_BIT]  <= 1'b0;
          bus.mcu_bus[`SER_DATA_BIT] <= sdata[bit_idx];
          if (tmr == 8'h00) begin
            bus.mcu_bus[`SER_CLK_BIT] <= 1'b1;
            tmr   <= 8'(`SCK_HALF_CYC - 1);
            state <= ST_SCK_HI;
          end
        end
        ST_SCK_HI: begin
          if (tmr == 8'h00) begin
            bus.mcu_bus[`SER_CLK_BIT] <= 1'b0;
            bit_idx <= bit_idx - 3'h1;
            tmr     <= (bit_idx == 3'h0) ? 8'(`HOLD_CYC - 1) : 8'(`SCK_HALF_CYC - 1);
            state   <= (bit_idx == 3'h0) ? ST_HOLD : ST_SCK_LO;
          end
        end
        ST_HOLD: begin
          if (tmr == 8'h00) begin
            bus.cs_n <= 1'b1;
            tmr      <= 8'(`GAP_CYC - 1);
            state    <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tmr == 8'h00) begin
            bus.mcu_bus    <= 8'h00;
            bus.mcu_bus_oe <= 8'hFF;
            rsp_valid_o    <= rd;
            state          <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : oled_mcu_end

/* File: bench/oled_host_bus_asserts.sv */
`timescale 1ns/100ps
module oled_host_bus_asserts (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       cs_n,
  input wire logic       e_rd,
  input wire logic       rw_wr,
  input wire logic       protocol_select_0,
  input wire logic       protocol_select_1,
  input wire logic [7:0] mcu_bus_oe,
  input wire logic [7:0] disp_bus_oe,
  input wire logic [7:0] host_data_bus
);
  logic       sel68;
  logic       sel80;
  logic       ser;
  logic       sck_prev;
  logic [3:0] sck_count;
  assign sel68 = protocol_select_1 & protocol_select_0;
  assign sel80 = protocol_select_1 & ~protocol_select_0;
  assign ser   = ~protocol_select_1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Rising serial clock edges seen in the current frame
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_prev  <= 1'b0;
      sck_count <= 4'h0;
    end else begin
      sck_prev <= host_data_bus[0];
      if (cs_n) begin
        sck_count <= 4'h0;
      end else if (host_data_bus[0] && !sck_prev) begin
        sck_count <= sck_count + 4'h1;
      end
    end
  end
  property p_no_contention;
    |disp_bus_oe |-> protocol_select_1 && mcu_bus_oe == 8'h00;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("display drives bus outside a parallel read");
  property p_drive_in_frame;
    |disp_bus_oe |-> !cs_n || !$past(cs_n, 5);
  endproperty
  a_drive_in_frame: assert property (p_drive_in_frame)
    else $error("display drives bus while deselected");
  property p_serial_strobes;
    ser && $past(ser, 2) |-> !e_rd && !rw_wr;
  endproperty
  a_serial_strobes: assert property (p_serial_strobes)
    else $error("strobe pins not grounded in serial mode");
  property p_serial_unused;
    ser |-> host_data_bus[7:3] == 5'h00;
  endproperty
  a_serial_unused: assert property (p_serial_unused)
    else $error("unused data pins not grounded in serial mode");
  property p_serial_data_stable;
    ser && !cs_n && $rose(host_data_bus[0]) |->
      $stable(host_data_bus[1]) ##1 host_data_bus[0] && $stable(host_data_bus[1]);
  endproperty
  a_serial_data_stable: assert property (p_serial_data_stable)
    else $error("serial data moves while serial clock high");
  property p_serial_eight;
    $rose(cs_n) && ser && $past(ser) |-> sck_count == 4'h8;
  endproperty
  a_serial_eight: assert property (p_serial_eight)
    else $error("serial frame without eight clocks");
  property p_m68_strobe;
    sel68 && $past(sel68, 2) && e_rd |-> !cs_n && $stable(rw_wr);
  endproperty
  a_m68_strobe: assert property (p_m68_strobe)
    else $error("enable high without select or with direction moving");
  property p_i80_write;
    sel80 && $past(sel80, 2) && $fell(rw_wr) |-> (!cs_n && !rw_wr) [*3] ##1 (!cs_n && rw_wr);
  endproperty
  a_i80_write: assert property (p_i80_write)
    else $error("write strobe shape wrong");
  property p_i80_read;
    sel80 && $past(sel80, 2) && $fell(e_rd) |->
      (!cs_n && !e_rd) [*8] ##1 !e_rd ##1 (!cs_n && e_rd);
  endproperty
  a_i80_read: assert property (p_i80_read)
    else $error("read strobe shape wrong");
endmodule : oled_host_bus_asserts

/* File: bench/test_oled_host_bus_interface.sv */
`timescale 1ns/100ps
module test_oled_host_bus_interface
  import oled_host_bus_pkg::*;
;
  logic       clk_i          = 1'b0;
  logic       link_clk_i     = 1'b0;
  logic       reset_i        = 1'b1;
  logic       hw_reset_req_i = 1'b0;
  logic       req_valid_i    = 1'b0;
  logic       req_read_i     = 1'b0;
  logic       req_dc_i       = 1'b0;
  logic [7:0] req_data_i     = 8'h00;
  logic       rx_ready_i     = 1'b0;
  logic [7:0] rd_data_i      = 8'h00;
  mode_t      mode_i         = MODE_SPI4;
  logic       req_ready_o, rsp_valid_o, rx_valid_o, rx_is_data_o, rx_room_o, overrun_o, rd_done_o;
  logic [7:0] rsp_data_o, rx_data_o;
  mode_t      mode_o;
  int         errors = 0, n_tests = 0, n_over = 0, n_done = 0;

  oled_host_bus_if bus_if ();
  oled_mcu_end u_oled_mcu_end (.clk_i, .reset_i, .ce_i(1'b1), .bus(bus_if), .mode_i,
    .hw_reset_req_i, .req_valid_i, .req_ready_o, .req_read_i, .req_dc_i, .req_data_i,
    .rsp_valid_o, .rsp_data_o);
  oled_display_end u_oled_display_end (.link_clk_i, .reset_i, .ce_i(1'b1), .bus(bus_if),
    .rx_valid_o, .rx_ready_i, .rx_data_o, .rx_is_data_o, .rx_room_o, .overrun_o,
    .rd_data_i, .rd_done_o, .mode_o);
  oled_host_bus_asserts u_oled_host_bus_asserts (.clk_i, .reset_i, .cs_n(bus_if.cs_n),
    .e_rd(bus_if.e_rd), .rw_wr(bus_if.rw_wr), .protocol_select_0(bus_if.protocol_select_0),
    .protocol_select_1(bus_if.protocol_select_1), .mcu_bus_oe(bus_if.mcu_bus_oe),
    .disp_bus_oe(bus_if.disp_bus_oe), .host_data_bus(bus_if.host_data_bus));

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #7;
    forever #16 link_clk_i = ~link_clk_i;
  end
  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge link_clk_i) begin
    if (overrun_o === 1'b1) n_over++;
    if (rd_done_o === 1'b1) n_done++;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic timed_out();
    errors++;
    complete_run();
  endtask : timed_out

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One host request; called at a falling edge of clk_i, or of link_clk_i right after a pop
  task automatic host_op(input logic rd, input logic dcv, input logic [7:0] d,
                         output logic [7:0] q);
    int n;
    n = 0;
    req_read_i  = rd;
    req_dc_i    = dcv;
    req_data_i  = d;
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1) begin
      @(negedge clk_i);
      if (++n > 60) timed_out();
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    while ((rd ? rsp_valid_o : req_ready_o) !== 1'b1) begin
      @(negedge clk_i);
      if (++n > 120) timed_out();
    end
    q = rsp_data_o;
  endtask : host_op

  // Takes one received byte from the display end and compares it
  task automatic pop(input logic [7:0] d, input logic isd);
    int n;
    n = 0;
    @(negedge link_clk_i);
    while (rx_valid_o !== 1'b1) begin
      @(negedge link_clk_i);
      if (++n > 200) timed_out();
    end
    check(rx_data_o, d);
    check({7'h00, rx_is_data_o}, {7'h00, isd});
    rx_ready_i = 1'b1;
    @(negedge link_clk_i);
    rx_ready_i = 1'b0;
  endtask : pop

  initial begin
    logic [7:0] q;
    mode_t      m;
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      m      = mode_t'(i);
      mode_i = m;
      repeat (6) @(negedge clk_i);
      check({6'h00, mode_o}, {6'h00, m});
      host_op(1'b0, 1'b1, 8'hA5 ^ 8'(i), q);
      host_op(1'b0, 1'b0, 8'h3C, q);
      pop(8'hA5 ^ 8'(i), m != MODE_SPI3);
      pop(8'h3C, 1'b0);
      rd_data_i = 8'h5A + 8'(i);
      host_op(1'b1, 1'b1, 8'h00, q);
      check(q, m[1] ? rd_data_i : 8'h00);
    end
    check(8'(n_done), 8'h02);
    // Third byte finds the two-entry buffer full and is lost
    for (int i = 0; i < 3; i++) host_op(1'b0, 1'b1, 8'(i), q);
    repeat (8) @(negedge link_clk_i);
    check({7'h00, rx_room_o}, 8'h00);
    check(8'(n_over), 8'h01);
    pop(8'h00, 1'b1);
    pop(8'h01, 1'b1);
    check({7'h00, rx_valid_o}, 8'h00);
    check({7'h00, rx_room_o}, 8'h01);
    // Device reset request discards a pending byte
    @(negedge clk_i);
    host_op(1'b0, 1'b0, 8'h77, q);
    // The byte must be waiting before the device reset can discard it
    repeat (4) @(negedge link_clk_i);
    check({7'h00, rx_valid_o}, 8'h01);
    @(negedge clk_i);
    hw_reset_req_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check({7'h00, bus_if.hard_reset_n}, 8'h00);
    check({7'h00, rx_valid_o}, 8'h00);
    hw_reset_req_i = 1'b0;
    repeat (6) @(negedge clk_i);
    host_op(1'b0, 1'b1, 8'h81, q);
    pop(8'h81, 1'b1);
    complete_run();
  end
endmodule : test_oled_host_bus_interface
